// file: design/capture_pkg.sv
// constants shared by the event capture channel
package capture_pkg;

  // register byte offsets, one aligned word each
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_TRIGGER_SELECT = 8'h04;
  localparam logic [7:0] OFS_VALUE_LOW = 8'h08;
  localparam logic [7:0] OFS_VALUE_HIGH = 8'h0c;
  localparam logic [7:0] OFS_TIMER_ASSIGN0 = 8'h10;
  localparam logic [7:0] OFS_TIMER_ASSIGN1 = 8'h14;
  localparam logic [7:0] OFS_FLAG = 8'h18;
  localparam logic [7:0] OFS_TIME_BASE = 8'h1c;

  // register bit positions and field widths
  localparam int unsigned CTRL_ENABLE_BIT = 7;
  localparam int unsigned CTRL_OPEN_DRAIN_BIT = 6;
  localparam int unsigned MODE_W = 4;
  localparam int unsigned FLAG_BIT = 0;
  localparam int unsigned TIMER_SEL_W = 2;
  localparam int unsigned TRIG_SEL_W = 3;

  // reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [2:0] TRIGGER_SELECT_RESET = 3'h0;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  localparam logic [7:0] TIMER_ASSIGN_RESET = 8'h00;

  // capture event modes
  localparam logic [3:0] MODE_EVERY_EDGE = 4'h3;
  localparam logic [3:0] MODE_FALLING = 4'h4;
  localparam logic [3:0] MODE_RISING = 4'h5;
  localparam logic [3:0] MODE_RISING_4TH = 4'h6;
  localparam logic [3:0] MODE_RISING_16TH = 4'h7;
  localparam logic [3:0] MODE_CAPTURE_LAST = 4'h7;
  localparam logic [3:0] MODE_COMPARE_FIRST = 4'h8;
  localparam logic [3:0] MODE_PULSE_FIRST = 4'hc;

  // trigger source codes, 5 to 7 reserved
  localparam logic [2:0] TRIG_PIN = 3'h0;
  localparam logic [2:0] TRIG_CMP1 = 3'h1;
  localparam logic [2:0] TRIG_CMP2 = 3'h2;
  localparam logic [2:0] TRIG_CMP3 = 3'h3;
  localparam logic [2:0] TRIG_PIN_CHANGE = 3'h4;

  // edge prescaler
  localparam int unsigned PRESCALE_W = 4;
  localparam logic [1:0] PRESCALE_4TH_MATCH = 2'h3;
  localparam logic [3:0] PRESCALE_16TH_MATCH = 4'hf;

  typedef enum logic [1:0] {
    GROUP_OFF = 2'b00,
    GROUP_CAPTURE = 2'b01,
    GROUP_COMPARE = 2'b11,
    GROUP_PULSE = 2'b10
  } mode_group_t;

endpackage

// file: design/capture_trigger.sv
// trigger synchroniser, edge detector and edge prescaler
`timescale 1ns/1ps
module capture_trigger (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // trigger and setup
  input wire logic trigger_raw,
  input wire logic [3:0] mode,
  input wire logic capture_active,
  // event out
  output logic event_pulse
);

  logic sync1_reg;
  logic sync2_reg;
  logic last_reg;
  logic event_reg;
  logic event_next;
  logic [capture_pkg::PRESCALE_W-1:0] prescale_reg;
  logic [capture_pkg::PRESCALE_W-1:0] prescale_next;

  wire rising = sync2_reg & ~last_reg;
  wire falling = ~sync2_reg & last_reg;
  wire hit_4th = rising & (prescale_reg[1:0] == capture_pkg::PRESCALE_4TH_MATCH);
  wire hit_16th = rising & (prescale_reg == capture_pkg::PRESCALE_16TH_MATCH);

  // qualifying edge per mode
  assign event_next = capture_active & (
    ((mode == capture_pkg::MODE_EVERY_EDGE) & (rising | falling)) |
    ((mode == capture_pkg::MODE_FALLING) & falling) |
    ((mode == capture_pkg::MODE_RISING) & rising) |
    ((mode == capture_pkg::MODE_RISING_4TH) & hit_4th) |
    ((mode == capture_pkg::MODE_RISING_16TH) & hit_16th));

  // counter runs on rising edges, cleared only when idle
  assign prescale_next = !capture_active ? '0 :
                         rising ? prescale_reg + 4'h1 : prescale_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      last_reg <= 1'b0;
      event_reg <= 1'b0;
      prescale_reg <= '0;
    end else begin
      sync1_reg <= trigger_raw;
      sync2_reg <= sync1_reg;
      last_reg <= sync2_reg;
      event_reg <= event_next;
      prescale_reg <= prescale_next;
    end
  end

  assign event_pulse = event_reg;

  a_prescale_idle_clear: assert property (@(posedge clk) disable iff (rst)
    !capture_active |=> prescale_reg == '0) else $error("prescaler not cleared while idle");
  a_rising_mode_event: assert property (@(posedge clk) disable iff (rst)
    capture_active && mode == capture_pkg::MODE_RISING && rising |=> event_pulse)
    else $error("rising edge not captured");
  a_falling_no_rise: assert property (@(posedge clk) disable iff (rst)
    mode == capture_pkg::MODE_FALLING && !falling |=> !event_pulse)
    else $error("falling mode fired without falling edge");

endmodule

// file: design/event_capture_unit.sv
// capture channel with wishbone register file
// Behaviour
// - event copies full 16-bit timer count
// - mode picks falling, rising, 4th, 16th, both
// - capture sets flag; only software clears it
// - new capture overwrites old value, no overrun
// - source select: pin, comparators, pin change
// - capture time base is selected odd timer
// - pulse-width mode uses selected even timer
// - per-channel timer field allows shared timers
// - control, trigger select, value low/high registers
// - output modes offer open-drain pin driver
// - pin edges from own output still capture; the pin is released in capture modes, so own output never drives it then
// - prescaler clears when off or not capturing
// - capture works whenever timer count moves
//
// Local design decisions: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
module event_capture_unit #(
  parameter int unsigned CHANNEL_INDEX = 0
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // trigger sources
  input wire logic ROUTED_INPUT_PIN,
  input wire logic COMPARATOR_ONE_OUT,
  input wire logic COMPARATOR_TWO_OUT,
  input wire logic COMPARATOR_THREE_OUT,
  input wire logic PIN_CHANGE_INTERRUPT,
  // odd 16-bit timers
  input wire logic [15:0] ODD_TIMER1_COUNT,
  input wire logic [15:0] ODD_TIMER3_COUNT,
  input wire logic [15:0] ODD_TIMER5_COUNT,
  input wire logic [15:0] ODD_TIMER7_COUNT,
  // even 8-bit timers
  input wire logic [7:0] EVEN_TIMER2_COUNT,
  input wire logic [7:0] EVEN_TIMER4_COUNT,
  input wire logic [7:0] EVEN_TIMER6_COUNT,
  input wire logic [7:0] EVEN_TIMER8_COUNT,
  // channel pin
  input wire logic OUTPUT_LEVEL,
  input wire logic PIN_DIRECTION_BIT,
  output logic CHANNEL_PIN_OUT,
  output logic CHANNEL_PIN_OE_N,
  // status
  output logic CHANNEL_EVENT_FLAG
);

  localparam bit ASSIGN_IN_REG1 = (CHANNEL_INDEX >= 4);
  localparam int unsigned FIELD_LSB = (CHANNEL_INDEX % 4) * 2;

  logic [7:0] channel_control_reg;
  logic [2:0] trigger_select_reg;
  logic [15:0] capture_value_reg;
  logic [7:0] timer_assign_reg0;
  logic [7:0] timer_assign_reg1;
  logic channel_event_flag_reg;
  logic channel_event_flag_next;
  logic ack_reg;
  logic [31:0] dat_o_reg;
  logic pin_out_reg;
  logic pin_oe_n_reg;
  logic event_pulse;
  capture_pkg::mode_group_t group;

  // bus decode
  wire request = WB_CYC_I & WB_STB_I & ~ack_reg;
  wire wr_en = request & WB_WE_I & WB_SEL_I[0];
  wire rd_en = request & ~WB_WE_I;
  wire wr_control = wr_en & (WB_ADR_I == capture_pkg::OFS_CONTROL);
  wire wr_trigger = wr_en & (WB_ADR_I == capture_pkg::OFS_TRIGGER_SELECT);
  wire wr_low = wr_en & (WB_ADR_I == capture_pkg::OFS_VALUE_LOW);
  wire wr_high = wr_en & (WB_ADR_I == capture_pkg::OFS_VALUE_HIGH);
  wire wr_assign0 = wr_en & (WB_ADR_I == capture_pkg::OFS_TIMER_ASSIGN0);
  wire wr_assign1 = wr_en & (WB_ADR_I == capture_pkg::OFS_TIMER_ASSIGN1);
  wire wr_flag = wr_en & (WB_ADR_I == capture_pkg::OFS_FLAG);
  wire flag_clear = wr_flag & WB_DAT_I[capture_pkg::FLAG_BIT];

  // control fields
  wire enable = channel_control_reg[capture_pkg::CTRL_ENABLE_BIT];
  wire open_drain = channel_control_reg[capture_pkg::CTRL_OPEN_DRAIN_BIT];
  wire [3:0] mode = channel_control_reg[capture_pkg::MODE_W-1:0];

  // mode group classification
  assign group = (mode >= capture_pkg::MODE_PULSE_FIRST) ? capture_pkg::GROUP_PULSE :
                 (mode >= capture_pkg::MODE_COMPARE_FIRST) ? capture_pkg::GROUP_COMPARE :
                 (mode >= capture_pkg::MODE_EVERY_EDGE) ? capture_pkg::GROUP_CAPTURE :
                 capture_pkg::GROUP_OFF;
  wire capture_active = enable & (group == capture_pkg::GROUP_CAPTURE);
  wire output_mode = enable & ((group == capture_pkg::GROUP_COMPARE) | (group == capture_pkg::GROUP_PULSE));

  // per-channel timer field; other channels may pick the same timer
  wire [1:0] timer_sel = ASSIGN_IN_REG1 ? timer_assign_reg1[FIELD_LSB +: capture_pkg::TIMER_SEL_W] :
                                          timer_assign_reg0[FIELD_LSB +: capture_pkg::TIMER_SEL_W];

  // capture time base from odd timers
  wire [15:0] odd_count = (timer_sel == 2'h0) ? ODD_TIMER1_COUNT :
                          (timer_sel == 2'h1) ? ODD_TIMER3_COUNT :
                          (timer_sel == 2'h2) ? ODD_TIMER5_COUNT : ODD_TIMER7_COUNT;

  // pulse-width time base from even timers
  wire [7:0] even_count = (timer_sel == 2'h0) ? EVEN_TIMER2_COUNT :
                          (timer_sel == 2'h1) ? EVEN_TIMER4_COUNT :
                          (timer_sel == 2'h2) ? EVEN_TIMER6_COUNT : EVEN_TIMER8_COUNT;

  wire [15:0] time_base = (group == capture_pkg::GROUP_PULSE) ? {8'h00, even_count} : odd_count;

  // trigger source select, reserved codes give no trigger
  wire trigger_raw = (trigger_select_reg == capture_pkg::TRIG_PIN) ? ROUTED_INPUT_PIN :
                     (trigger_select_reg == capture_pkg::TRIG_CMP1) ? COMPARATOR_ONE_OUT :
                     (trigger_select_reg == capture_pkg::TRIG_CMP2) ? COMPARATOR_TWO_OUT :
                     (trigger_select_reg == capture_pkg::TRIG_CMP3) ? COMPARATOR_THREE_OUT :
                     (trigger_select_reg == capture_pkg::TRIG_PIN_CHANGE) ? PIN_CHANGE_INTERRUPT :
                     1'b0;

  capture_trigger u_trigger (
    .clk(REF_CLK),
    .rst(RST),
    .trigger_raw(trigger_raw),
    .mode(mode),
    .capture_active(capture_active),
    .event_pulse(event_pulse)
  );

  // flag: capture beats a software clear
  assign channel_event_flag_next = event_pulse | (channel_event_flag_reg & ~flag_clear);

  // read mux, unmapped reads zero
  wire [31:0] rd_data =
    (WB_ADR_I == capture_pkg::OFS_CONTROL) ? {24'h000000, channel_control_reg} :
    (WB_ADR_I == capture_pkg::OFS_TRIGGER_SELECT) ? {29'h0, trigger_select_reg} :
    (WB_ADR_I == capture_pkg::OFS_VALUE_LOW) ? {24'h000000, capture_value_reg[7:0]} :
    (WB_ADR_I == capture_pkg::OFS_VALUE_HIGH) ? {24'h000000, capture_value_reg[15:8]} :
    (WB_ADR_I == capture_pkg::OFS_TIMER_ASSIGN0) ? {24'h000000, timer_assign_reg0} :
    (WB_ADR_I == capture_pkg::OFS_TIMER_ASSIGN1) ? {24'h000000, timer_assign_reg1} :
    (WB_ADR_I == capture_pkg::OFS_FLAG) ? {31'h0, channel_event_flag_reg} :
    (WB_ADR_I == capture_pkg::OFS_TIME_BASE) ? {16'h0000, time_base} :
    32'h00000000;

  // pin driver, direction bit set means input
  wire drive_pin = output_mode & ~PIN_DIRECTION_BIT;
  wire pin_out_next = drive_pin & ~open_drain & OUTPUT_LEVEL;
  wire pin_oe_n_next = ~drive_pin | (open_drain & OUTPUT_LEVEL);

  // bus handshake
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ack_reg <= 1'b0;
      dat_o_reg <= 32'h00000000;
    end else begin
      ack_reg <= request;
      dat_o_reg <= rd_en ? rd_data : 32'h00000000;
    end
  end

  // configuration registers
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      channel_control_reg <= capture_pkg::CONTROL_RESET;
      trigger_select_reg <= capture_pkg::TRIGGER_SELECT_RESET;
      timer_assign_reg0 <= capture_pkg::TIMER_ASSIGN_RESET;
      timer_assign_reg1 <= capture_pkg::TIMER_ASSIGN_RESET;
    end else begin
      if (wr_control) begin
        channel_control_reg <= WB_DAT_I[7:0];
      end
      if (wr_trigger) begin
        trigger_select_reg <= WB_DAT_I[capture_pkg::TRIG_SEL_W-1:0];
      end
      if (wr_assign0) begin
        timer_assign_reg0 <= WB_DAT_I[7:0];
      end
      if (wr_assign1) begin
        timer_assign_reg1 <= WB_DAT_I[7:0];
      end
    end
  end

  // captured value and flag
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      capture_value_reg <= capture_pkg::VALUE_RESET;
      channel_event_flag_reg <= 1'b0;
    end else begin
      if (event_pulse) begin
        capture_value_reg <= odd_count;
      end else if (wr_low) begin
        capture_value_reg[7:0] <= WB_DAT_I[7:0];
      end else if (wr_high) begin
        capture_value_reg[15:8] <= WB_DAT_I[7:0];
      end
      channel_event_flag_reg <= channel_event_flag_next;
    end
  end

  // pin registers; the routed pin is sampled whatever drives it
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pin_out_reg <= 1'b0;
      pin_oe_n_reg <= 1'b1;
    end else begin
      pin_out_reg <= pin_out_next;
      pin_oe_n_reg <= pin_oe_n_next;
    end
  end

  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = dat_o_reg;
  assign CHANNEL_PIN_OUT = pin_out_reg;
  assign CHANNEL_PIN_OE_N = pin_oe_n_reg;
  assign CHANNEL_EVENT_FLAG = channel_event_flag_reg;

  // checks
  a_capture_loads_count: assert property (@(posedge REF_CLK) disable iff (RST)
    event_pulse |=> capture_value_reg == $past(odd_count))
    else $error("captured value differs from timer count");
  a_overwrite_value: assert property (@(posedge REF_CLK) disable iff (RST)
    event_pulse ##1 event_pulse |=> capture_value_reg == $past(odd_count))
    else $error("second capture did not overwrite");
  a_flag_set_capture: assert property (@(posedge REF_CLK) disable iff (RST)
    event_pulse |=> CHANNEL_EVENT_FLAG)
    else $error("flag not set by capture");
  a_flag_sticky: assert property (@(posedge REF_CLK) disable iff (RST)
    CHANNEL_EVENT_FLAG && !flag_clear |=> CHANNEL_EVENT_FLAG)
    else $error("flag dropped without software clear");
  a_flag_clear_works: assert property (@(posedge REF_CLK) disable iff (RST)
    flag_clear && !event_pulse |=> !CHANNEL_EVENT_FLAG)
    else $error("flag clear ignored");
  a_capture_only_active: assert property (@(posedge REF_CLK) disable iff (RST)
    $rose(event_pulse) |-> $past(capture_active, 1))
    else $error("capture outside capture mode");
  a_value_steady_idle: assert property (@(posedge REF_CLK) disable iff (RST)
    !event_pulse && !wr_low && !wr_high |=> $stable(capture_value_reg))
    else $error("captured value changed without cause");
  a_open_drain_release: assert property (@(posedge REF_CLK) disable iff (RST)
    drive_pin && open_drain && OUTPUT_LEVEL |=> CHANNEL_PIN_OE_N && !CHANNEL_PIN_OUT)
    else $error("open drain drove high level");
  a_push_pull_drive: assert property (@(posedge REF_CLK) disable iff (RST)
    drive_pin && !open_drain |=> !CHANNEL_PIN_OE_N && CHANNEL_PIN_OUT == $past(OUTPUT_LEVEL))
    else $error("push pull not driving");
  a_no_drive_input: assert property (@(posedge REF_CLK) disable iff (RST)
    PIN_DIRECTION_BIT |=> CHANNEL_PIN_OE_N)
    else $error("pin driven while set as input");
  a_ack_one_cycle: assert property (@(posedge REF_CLK) disable iff (RST)
    WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O)
    else $error("bus ack not a single cycle after request");
  a_low_half_read: assert property (@(posedge REF_CLK) disable iff (RST)
    rd_en && WB_ADR_I == capture_pkg::OFS_VALUE_LOW |=> WB_DAT_O == {24'h000000, $past(capture_value_reg[7:0])})
    else $error("low half read wrong");
  a_pulse_time_base: assert property (@(posedge REF_CLK) disable iff (RST)
    rd_en && WB_ADR_I == capture_pkg::OFS_TIME_BASE && group == capture_pkg::GROUP_PULSE
    |=> WB_DAT_O == {24'h000000, $past(even_count)})
    else $error("pulse width time base not even timer");

  // flag and capture timing
  a_set_beats_clear: assert property (@(posedge REF_CLK) disable iff (RST)
    event_pulse && flag_clear |=> CHANNEL_EVENT_FLAG)
    else $error("clear won over a capture");

  a_flag_needs_event: assert property (@(posedge REF_CLK) disable iff (RST)
    $rose(CHANNEL_EVENT_FLAG) |-> $past(event_pulse))
    else $error("flag set without capture");

  a_capture_sets_both: assert property (@(posedge REF_CLK) disable iff (RST)
    event_pulse |=> CHANNEL_EVENT_FLAG && capture_value_reg == $past(odd_count))
    else $error("flag and value not updated together");

  a_idle_no_capture: assert property (@(posedge REF_CLK) disable iff (RST)
    !capture_active |=> !event_pulse)
    else $error("capture while channel idle");

  // trigger source routing
  a_reserved_no_trigger: assert property (@(posedge REF_CLK) disable iff (RST)
    trigger_select_reg > capture_pkg::TRIG_PIN_CHANGE |-> !trigger_raw)
    else $error("reserved source gave a trigger");

  a_pin_source: assert property (@(posedge REF_CLK) disable iff (RST)
    trigger_select_reg == capture_pkg::TRIG_PIN |-> trigger_raw == ROUTED_INPUT_PIN)
    else $error("routed pin not selected");

  a_cmp1_source: assert property (@(posedge REF_CLK) disable iff (RST)
    trigger_select_reg == capture_pkg::TRIG_CMP1 |-> trigger_raw == COMPARATOR_ONE_OUT)
    else $error("comparator one not selected");

  a_cmp2_source: assert property (@(posedge REF_CLK) disable iff (RST)
    trigger_select_reg == capture_pkg::TRIG_CMP2 |-> trigger_raw == COMPARATOR_TWO_OUT)
    else $error("comparator two not selected");

  a_cmp3_source: assert property (@(posedge REF_CLK) disable iff (RST)
    trigger_select_reg == capture_pkg::TRIG_CMP3 |-> trigger_raw == COMPARATOR_THREE_OUT)
    else $error("comparator three not selected");

  a_pin_change_source: assert property (@(posedge REF_CLK) disable iff (RST)
    trigger_select_reg == capture_pkg::TRIG_PIN_CHANGE |-> trigger_raw == PIN_CHANGE_INTERRUPT)
    else $error("pin change source not selected");

  // register access
  a_capture_base_odd: assert property (@(posedge REF_CLK) disable iff (RST)
    rd_en && WB_ADR_I == capture_pkg::OFS_TIME_BASE && group != capture_pkg::GROUP_PULSE
    |=> WB_DAT_O == {16'h0000, $past(odd_count)})
    else $error("capture time base not odd timer");

  a_high_half_read: assert property (@(posedge REF_CLK) disable iff (RST)
    rd_en && WB_ADR_I == capture_pkg::OFS_VALUE_HIGH |=> WB_DAT_O == {24'h000000, $past(capture_value_reg[15:8])})
    else $error("high half read wrong");

  a_control_write: assert property (@(posedge REF_CLK) disable iff (RST)
    wr_control |=> channel_control_reg == $past(WB_DAT_I[7:0]))
    else $error("control write lost");

  a_low_half_write: assert property (@(posedge REF_CLK) disable iff (RST)
    wr_low && !event_pulse |=> capture_value_reg[7:0] == $past(WB_DAT_I[7:0]))
    else $error("low half write lost");

  a_dat_zero_idle: assert property (@(posedge REF_CLK) disable iff (RST)
    !WB_ACK_O |-> WB_DAT_O == 32'h00000000)
    else $error("read data outside ack");

  // pin released outside output modes
  a_output_off_release: assert property (@(posedge REF_CLK) disable iff (RST)
    !output_mode |=> CHANNEL_PIN_OE_N && !CHANNEL_PIN_OUT)
    else $error("pin driven outside output modes");

  c_capture_event: cover property (@(posedge REF_CLK) disable iff (RST) event_pulse);
  c_flag_cleared: cover property (@(posedge REF_CLK) disable iff (RST)
    CHANNEL_EVENT_FLAG ##1 !CHANNEL_EVENT_FLAG);
  c_sixteenth_mode: cover property (@(posedge REF_CLK) disable iff (RST)
    event_pulse && mode == capture_pkg::MODE_RISING_16TH);
  c_value_read: cover property (@(posedge REF_CLK) disable iff (RST)
    rd_en && WB_ADR_I == capture_pkg::OFS_VALUE_HIGH);
  c_every_edge_mode: cover property (@(posedge REF_CLK) disable iff (RST)
    event_pulse && mode == capture_pkg::MODE_EVERY_EDGE);

endmodule

// file: tb/tb.sv
// self-checking bench for the event capture channel
`timescale 1ns/1ps
module tb;
  logic clk, rst, cyc, stb, we, lvl, dir, run, pin_out, oe_n, flag, ack;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dati, dato, rd;
  logic [4:0] src;
  logic [15:0] odd [4];
  logic [7:0] even [4];
  logic [15:0] exp_val;
  logic [7:0] lo;
  int err_count, samples_checked, cycles;

  event_capture_unit #(.CHANNEL_INDEX(0)) i_event_capture_unit (
    .REF_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dati), .WB_DAT_O(dato), .WB_ACK_O(ack),
    .ROUTED_INPUT_PIN(src[0]), .COMPARATOR_ONE_OUT(src[1]), .COMPARATOR_TWO_OUT(src[2]),
    .COMPARATOR_THREE_OUT(src[3]), .PIN_CHANGE_INTERRUPT(src[4]),
    .ODD_TIMER1_COUNT(odd[0]), .ODD_TIMER3_COUNT(odd[1]), .ODD_TIMER5_COUNT(odd[2]),
    .ODD_TIMER7_COUNT(odd[3]), .EVEN_TIMER2_COUNT(even[0]), .EVEN_TIMER4_COUNT(even[1]),
    .EVEN_TIMER6_COUNT(even[2]), .EVEN_TIMER8_COUNT(even[3]), .OUTPUT_LEVEL(lvl),
    .PIN_DIRECTION_BIT(dir), .CHANNEL_PIN_OUT(pin_out), .CHANNEL_PIN_OE_N(oe_n),
    .CHANNEL_EVENT_FLAG(flag));

  timer_bank i_timer_bank (.clk(clk), .rst(rst), .run(run), .odd_count(odd), .even_count(even));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input string name, input logic [31:0] want, input logic [31:0] got);
    samples_checked++;
    if (got !== want) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, want, got);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dati <= d;
    sel <= 4'h1;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    rd = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic cfg(input logic [2:0] code, input logic [1:0] k, input logic [3:0] m);
    wb(1'b1, capture_pkg::OFS_TIMER_ASSIGN0, {30'h0, k});
    wb(1'b1, capture_pkg::OFS_TRIGGER_SELECT, {29'h0, code});
    wb(1'b1, capture_pkg::OFS_CONTROL, {24'h0, 4'h8, m});
  endtask

  task automatic fire(input int s, input logic v, input logic [1:0] k, input logic hit);
    wb(1'b1, capture_pkg::OFS_FLAG, 32'h1);
    @(posedge clk);
    src[s] <= v;
    repeat (3) @(posedge clk);
    #1 exp_val = odd[k];
    @(posedge clk);
    #1 check("flag", {31'h0, hit}, {31'h0, flag});
    if (hit) begin
      wb(1'b0, capture_pkg::OFS_VALUE_LOW, 32'h0);
      lo = rd[7:0];
      wb(1'b0, capture_pkg::OFS_VALUE_HIGH, 32'h0);
      check("value", {16'h0, exp_val}, {16'h0, rd[7:0], lo});
    end
  endtask

  task automatic test_regs();
    logic [7:0] addrs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h20};
    foreach (addrs[i]) begin
      wb(1'b0, addrs[i], 32'h0);
      check("reset read", 32'h0, rd);
    end
    wb(1'b1, capture_pkg::OFS_CONTROL, 32'h4d);
    wb(1'b0, capture_pkg::OFS_CONTROL, 32'h0);
    check("control", 32'h4d, rd);
    wb(1'b1, capture_pkg::OFS_CONTROL, 32'h0);
    $display("test regs done");
  endtask

  task automatic test_sources();
    for (int c = 0; c < 5; c++) begin
      cfg(3'(c), 2'(c), capture_pkg::MODE_RISING);
      fire(c, 1'b1, 2'(c), 1'b1);
      fire(c, 1'b0, 2'(c), 1'b0);
      fire(c, 1'b1, 2'(c), 1'b1);
      fire(c, 1'b0, 2'(c), 1'b0);
    end
    $display("test sources done");
  endtask

  task automatic test_modes();
    logic [3:0] m [3] = '{capture_pkg::MODE_EVERY_EDGE, capture_pkg::MODE_FALLING, capture_pkg::MODE_RISING};
    logic up [3] = '{1'b1, 1'b0, 1'b1};
    logic dn [3] = '{1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 3; i++) begin
      cfg(capture_pkg::TRIG_PIN, 2'h1, m[i]);
      fire(0, 1'b1, 2'h1, up[i]);
      fire(0, 1'b0, 2'h1, dn[i]);
    end
    $display("test modes done");
  endtask

  task automatic test_prescale();
    int n [3] = '{4, 16, 3};
    for (int j = 0; j < 3; j++) begin
      if (j < 2) begin
        wb(1'b1, capture_pkg::OFS_CONTROL, 32'h0);
      end
      cfg(capture_pkg::TRIG_PIN, 2'h3, j == 0 ? capture_pkg::MODE_RISING_4TH : capture_pkg::MODE_RISING_16TH);
      if (j == 2) begin
        fire(0, 1'b1, 2'h3, 1'b0);
        fire(0, 1'b0, 2'h3, 1'b0);
        cfg(capture_pkg::TRIG_PIN, 2'h3, capture_pkg::MODE_RISING_4TH);
      end
      for (int i = 1; i <= n[j]; i++) begin
        fire(0, 1'b1, 2'h3, i == n[j]);
        fire(0, 1'b0, 2'h3, 1'b0);
      end
    end
    $display("test prescale done");
  endtask

  task automatic test_reserved();
    cfg(3'h5, 2'h0, capture_pkg::MODE_EVERY_EDGE);
    for (int s = 0; s < 5; s++) begin
      fire(s, 1'b1, 2'h0, 1'b0);
      fire(s, 1'b0, 2'h0, 1'b0);
    end
    $display("test reserved done");
  endtask

  task automatic test_sticky();
    cfg(capture_pkg::TRIG_PIN, 2'h0, capture_pkg::MODE_RISING);
    fire(0, 1'b1, 2'h0, 1'b1);
    repeat (20) @(posedge clk);
    wb(1'b1, capture_pkg::OFS_FLAG, 32'h0);
    wb(1'b0, capture_pkg::OFS_FLAG, 32'h0);
    check("sticky flag", 32'h1, rd);
    wb(1'b1, capture_pkg::OFS_FLAG, 32'h1);
    wb(1'b0, capture_pkg::OFS_FLAG, 32'h0);
    check("cleared flag", 32'h0, rd);
    fire(0, 1'b0, 2'h0, 1'b0);
    $display("test sticky done");
  endtask

  task automatic pin(input logic l, input logic d, input logic [1:0] want);
    @(posedge clk);
    lvl <= l;
    dir <= d;
    repeat (3) @(posedge clk);
    #1 check("pin", {30'h0, want}, {30'h0, oe_n, pin_out});
  endtask

  task automatic test_pin();
    run <= 1'b0;
    wb(1'b1, capture_pkg::OFS_TIMER_ASSIGN0, 32'h2);
    wb(1'b1, capture_pkg::OFS_CONTROL, 32'h8c);
    pin(1'b1, 1'b0, 2'b01);
    wb(1'b0, capture_pkg::OFS_TIME_BASE, 32'h0);
    check("pulse base", {24'h0, even[2]}, rd);
    wb(1'b1, capture_pkg::OFS_CONTROL, 32'hcc);
    pin(1'b1, 1'b0, 2'b10);
    pin(1'b0, 1'b0, 2'b00);
    pin(1'b0, 1'b1, 2'b10);
    wb(1'b1, capture_pkg::OFS_CONTROL, 32'h85);
    wb(1'b0, capture_pkg::OFS_TIME_BASE, 32'h0);
    check("capture base", {16'h0, odd[2]}, rd);
    wb(1'b1, capture_pkg::OFS_CONTROL, 32'h0);
    run <= 1'b1;
    $display("test pin done");
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      stop_test();
    end
  end

  initial begin
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dati = 32'h0;
    src = 5'h00;
    lvl = 1'b0;
    dir = 1'b1;
    run = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    test_regs();
    test_sources();
    test_modes();
    test_prescale();
    test_reserved();
    test_sticky();
    test_pin();
    stop_test();
  end
endmodule

// file: tb/timer_bank.sv
// timer bank model feeding the capture channel
`timescale 1ns/1ps
module timer_bank (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // freeze control
  input wire logic run,
  // live counts
  output logic [15:0] odd_count [4],
  output logic [7:0] even_count [4]
);
  logic [1:0] div_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      div_reg <= 2'h0;
      for (int k = 0; k < 4; k++) begin
        odd_count[k] <= 16'h8421 + 16'(k * 16'h1357);
        even_count[k] <= 8'h31 + 8'(k * 8'h17);
      end
    end else if (run) begin
      div_reg <= div_reg + 2'h1;
      if (div_reg == 2'h3) begin
        for (int k = 0; k < 4; k++) begin
          odd_count[k] <= odd_count[k] + 16'h0101 + 16'(k);
          even_count[k] <= even_count[k] + 8'h01;
        end
      end
    end
  end
endmodule
